// ---- design/gpio_cn_pkg.sv ----
// constants for the i/o port with change notification
// Contract
// - direction one makes input, zero output
// - reset sets every pin to input
// - latch read returns latch, write stores latch
// - pin read returns pins, write hits latch
// - open drain pulls low, releases high
// - analog select resets to all ones
// - output still driven while analog selected
// - analog input pins read as zero
// - change detection works without a clock gate
// - every pin has its own notify enable
// - mismatch mode: positive enable arms any change
// - edge mode: negative falling, positive rising
// - mismatch status: changed since last pin read
// - edge flag records detected edge per pin
// - per pin weak pull-up and pull-down enables
// - clear, set, invert aliases at 4, 8, C
package gpio_cn_pkg;
  localparam int        NPINS          = 16;
  localparam int        ADDR_W         = 8;
  localparam int        DATA_W         = 32;
  // register index lives in addr[7:4], alias op in addr[3:2]
  localparam logic [3:0] IDX_ANALOG     = 4'h0;
  localparam logic [3:0] IDX_DIRECTION  = 4'h1;
  localparam logic [3:0] IDX_PIN_VALUE  = 4'h2;
  localparam logic [3:0] IDX_LATCH      = 4'h3;
  localparam logic [3:0] IDX_OPEN_DRAIN = 4'h4;
  localparam logic [3:0] IDX_PULLUP     = 4'h5;
  localparam logic [3:0] IDX_PULLDOWN   = 4'h6;
  localparam logic [3:0] IDX_CN_CTRL    = 4'h7;
  localparam logic [3:0] IDX_POS_EN     = 4'h8;
  localparam logic [3:0] IDX_STATUS     = 4'h9;
  localparam logic [3:0] IDX_NEG_EN     = 4'hA;
  localparam logic [3:0] IDX_EDGE_FLAG  = 4'hB;
  localparam logic [1:0] OP_WRITE       = 2'h0;
  localparam logic [1:0] OP_CLR         = 2'h1;
  localparam logic [1:0] OP_SET         = 2'h2;
  localparam logic [1:0] OP_INV         = 2'h3;
  localparam int        CN_ON_POS      = 15;
  localparam int        EDGE_MODE_POS  = 11;
  localparam logic [15:0] CN_CTRL_MASK   = 16'h8800;
  localparam logic [15:0] ANALOG_RESET   = 16'hFFFF;
  localparam logic [15:0] DIRECTION_RESET = 16'hFFFF;
  localparam logic [15:0] ZERO_RESET     = 16'h0000;
endpackage

// ---- design/io_port_change_notify.sv ----
// i/o port with direction, latch, open drain, analog select, pulls and change notification
`timescale 1ns/1ps
module io_port_change_notify (
  input  wire logic                              clk,
  input  wire logic                              sys_rst,
  input  wire logic [gpio_cn_pkg::ADDR_W-1:0]    addr,
  input  wire logic [gpio_cn_pkg::DATA_W-1:0]    wr_data,
  input  wire logic                              wr_en,
  input  wire logic                              rd_en,
  output logic      [gpio_cn_pkg::DATA_W-1:0]    rd_data,
  input  wire logic [gpio_cn_pkg::NPINS-1:0]     pin_in,
  output logic      [gpio_cn_pkg::NPINS-1:0]     pin_out,
  output logic      [gpio_cn_pkg::NPINS-1:0]     pin_oe,
  output logic      [gpio_cn_pkg::NPINS-1:0]     pullup_en,
  output logic      [gpio_cn_pkg::NPINS-1:0]     pulldown_en,
  output logic      [gpio_cn_pkg::NPINS-1:0]     analog_en,
  output logic                                   cn_irq
);
  typedef logic [gpio_cn_pkg::NPINS-1:0] pins_t;

  pins_t analog_select_reg;
  pins_t pin_direction_reg;
  pins_t output_latch_reg;
  pins_t open_drain_ctrl_reg;
  pins_t weak_pullup_enable_reg;
  pins_t weak_pulldown_enable_reg;
  pins_t change_notify_ctrl_reg;
  pins_t change_pos_enable_reg;
  pins_t change_neg_enable_reg;
  pins_t change_status_reg;
  pins_t change_edge_flag_reg;
  pins_t pin_level;
  pins_t level_prev;
  pins_t mismatch_ref;
  pins_t pin_value_reg;
  pins_t wdata16;
  pins_t next_rise;
  pins_t next_fall;
  pins_t next_mismatch;
  logic  cn_on;
  logic  edge_mode_select;
  logic  pin_value_read;

  // register index of an access
  function automatic logic [3:0] reg_index(input logic [gpio_cn_pkg::ADDR_W-1:0] a);
    reg_index = a[7:4];
  endfunction

  // alias operation of an access
  function automatic logic [1:0] reg_op(input logic [gpio_cn_pkg::ADDR_W-1:0] a);
    reg_op = a[3:2];
  endfunction

  // write strobe aimed at one register
  function automatic logic write_hit(input logic we, input logic [gpio_cn_pkg::ADDR_W-1:0] a,
                                     input logic [3:0] idx);
    write_hit = we && (reg_index(a) == idx);
  endfunction

  // plain, clear, set or invert update
  function automatic pins_t apply_op(input pins_t old, input pins_t wd, input logic [1:0] op);
    case (op)
      gpio_cn_pkg::OP_WRITE: apply_op = wd;
      gpio_cn_pkg::OP_CLR:   apply_op = old & ~wd;
      gpio_cn_pkg::OP_SET:   apply_op = old | wd;
      default:               apply_op = old ^ wd;
    endcase
  endfunction

  assign wdata16          = wr_data[gpio_cn_pkg::NPINS-1:0];
  assign cn_on            = change_notify_ctrl_reg[gpio_cn_pkg::CN_ON_POS];
  assign edge_mode_select = change_notify_ctrl_reg[gpio_cn_pkg::EDGE_MODE_POS];
  assign pin_value_read   = rd_en && (reg_index(addr) == gpio_cn_pkg::IDX_PIN_VALUE);

  pin_sync u_pin_sync (
    .clk       (clk),
    .sys_rst   (sys_rst),
    .pin_raw   (pin_in),
    .pin_level (pin_level)
  );

  // analog inputs read back as zero
  assign pin_value_reg = pin_level & ~(analog_select_reg & pin_direction_reg);

  // analog select
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      analog_select_reg <= gpio_cn_pkg::ANALOG_RESET;
    end else if (write_hit(wr_en, addr, gpio_cn_pkg::IDX_ANALOG)) begin
      analog_select_reg <= apply_op(analog_select_reg, wdata16, reg_op(addr));
    end
  end

  // direction
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      pin_direction_reg <= gpio_cn_pkg::DIRECTION_RESET;
    end else if (write_hit(wr_en, addr, gpio_cn_pkg::IDX_DIRECTION)) begin
      pin_direction_reg <= apply_op(pin_direction_reg, wdata16, reg_op(addr));
    end
  end

  // output latch, reached through latch and pin value addresses
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      output_latch_reg <= gpio_cn_pkg::ZERO_RESET;
    end else if (write_hit(wr_en, addr, gpio_cn_pkg::IDX_LATCH)) begin
      output_latch_reg <= apply_op(output_latch_reg, wdata16, reg_op(addr));
    end else if (write_hit(wr_en, addr, gpio_cn_pkg::IDX_PIN_VALUE)) begin
      output_latch_reg <= apply_op(output_latch_reg, wdata16, reg_op(addr));
    end
  end

  // open drain control
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      open_drain_ctrl_reg <= gpio_cn_pkg::ZERO_RESET;
    end else if (write_hit(wr_en, addr, gpio_cn_pkg::IDX_OPEN_DRAIN)) begin
      open_drain_ctrl_reg <= apply_op(open_drain_ctrl_reg, wdata16, reg_op(addr));
    end
  end

  // weak pull enables
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      weak_pullup_enable_reg   <= gpio_cn_pkg::ZERO_RESET;
      weak_pulldown_enable_reg <= gpio_cn_pkg::ZERO_RESET;
    end else begin
      if (write_hit(wr_en, addr, gpio_cn_pkg::IDX_PULLUP)) begin
        weak_pullup_enable_reg <= apply_op(weak_pullup_enable_reg, wdata16, reg_op(addr));
      end
      if (write_hit(wr_en, addr, gpio_cn_pkg::IDX_PULLDOWN)) begin
        weak_pulldown_enable_reg <= apply_op(weak_pulldown_enable_reg, wdata16, reg_op(addr));
      end
    end
  end

  // change notification control and enables
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      change_notify_ctrl_reg <= gpio_cn_pkg::ZERO_RESET;
      change_pos_enable_reg  <= gpio_cn_pkg::ZERO_RESET;
      change_neg_enable_reg  <= gpio_cn_pkg::ZERO_RESET;
    end else begin
      if (write_hit(wr_en, addr, gpio_cn_pkg::IDX_CN_CTRL)) begin
        change_notify_ctrl_reg <= apply_op(change_notify_ctrl_reg, wdata16, reg_op(addr))
                                  & gpio_cn_pkg::CN_CTRL_MASK;
      end
      if (write_hit(wr_en, addr, gpio_cn_pkg::IDX_POS_EN)) begin
        change_pos_enable_reg <= apply_op(change_pos_enable_reg, wdata16, reg_op(addr));
      end
      if (write_hit(wr_en, addr, gpio_cn_pkg::IDX_NEG_EN)) begin
        change_neg_enable_reg <= apply_op(change_neg_enable_reg, wdata16, reg_op(addr));
      end
    end
  end

  // previous level for edges, reference level refreshed by each pin value read
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      level_prev   <= gpio_cn_pkg::ZERO_RESET;
      mismatch_ref <= gpio_cn_pkg::ZERO_RESET;
    end else begin
      level_prev <= pin_level;
      if (pin_value_read) begin
        mismatch_ref <= pin_level;
      end
    end
  end

  // detection runs off synchronised levels with no sleep gating
  always_comb begin
    next_mismatch = gpio_cn_pkg::ZERO_RESET;
    next_rise     = gpio_cn_pkg::ZERO_RESET;
    next_fall     = gpio_cn_pkg::ZERO_RESET;
    if (cn_on) begin
      if (!edge_mode_select) begin
        next_mismatch = (pin_level ^ mismatch_ref) & change_pos_enable_reg;
      end else begin
        next_rise = pin_level & ~level_prev & change_pos_enable_reg;
        next_fall = ~pin_level & level_prev & change_neg_enable_reg;
      end
    end
  end

  // mismatch status: cleared by pin value read or software, detection wins over the software clear
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      change_status_reg <= gpio_cn_pkg::ZERO_RESET;
    end else begin
      if (write_hit(wr_en, addr, gpio_cn_pkg::IDX_STATUS)) begin
        change_status_reg <= apply_op(change_status_reg, wdata16, reg_op(addr)) | next_mismatch;
      end else if (pin_value_read) begin
        // the read reports the level now moved into the reference, so nothing is lost
        change_status_reg <= gpio_cn_pkg::ZERO_RESET;
      end else begin
        change_status_reg <= change_status_reg | next_mismatch;
      end
    end
  end

  // edge flag: cleared by software, detection wins
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      change_edge_flag_reg <= gpio_cn_pkg::ZERO_RESET;
    end else if (write_hit(wr_en, addr, gpio_cn_pkg::IDX_EDGE_FLAG)) begin
      change_edge_flag_reg <= apply_op(change_edge_flag_reg, wdata16, reg_op(addr))
                              | next_rise | next_fall;
    end else begin
      change_edge_flag_reg <= change_edge_flag_reg | next_rise | next_fall;
    end
  end

  // interrupt request
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      cn_irq <= 1'b0;
    end else begin
      cn_irq <= cn_on && (|(change_status_reg & change_pos_enable_reg)
                || |(change_edge_flag_reg & (change_pos_enable_reg | change_neg_enable_reg)));
    end
  end

  // pad drive
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      pin_out     <= gpio_cn_pkg::ZERO_RESET;
      pin_oe      <= gpio_cn_pkg::ZERO_RESET;
      pullup_en   <= gpio_cn_pkg::ZERO_RESET;
      pulldown_en <= gpio_cn_pkg::ZERO_RESET;
      analog_en   <= gpio_cn_pkg::ANALOG_RESET;
    end else begin
      pin_out     <= output_latch_reg & ~open_drain_ctrl_reg;
      // drive regardless of analog select; open drain releases on high
      pin_oe      <= ~pin_direction_reg & ~(open_drain_ctrl_reg & output_latch_reg);
      pullup_en   <= weak_pullup_enable_reg;
      pulldown_en <= weak_pulldown_enable_reg;
      analog_en   <= analog_select_reg;
    end
  end

  // read data valid in the cycle after the strobe only
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      rd_data <= '0;
    end else begin
      rd_data <= '0;
      if (rd_en) begin
        case (reg_index(addr))
          gpio_cn_pkg::IDX_ANALOG:     rd_data <= {16'h0000, analog_select_reg};
          gpio_cn_pkg::IDX_DIRECTION:  rd_data <= {16'h0000, pin_direction_reg};
          gpio_cn_pkg::IDX_PIN_VALUE:  rd_data <= {16'h0000, pin_value_reg};
          gpio_cn_pkg::IDX_LATCH:      rd_data <= {16'h0000, output_latch_reg};
          gpio_cn_pkg::IDX_OPEN_DRAIN: rd_data <= {16'h0000, open_drain_ctrl_reg};
          gpio_cn_pkg::IDX_PULLUP:     rd_data <= {16'h0000, weak_pullup_enable_reg};
          gpio_cn_pkg::IDX_PULLDOWN:   rd_data <= {16'h0000, weak_pulldown_enable_reg};
          gpio_cn_pkg::IDX_CN_CTRL:    rd_data <= {16'h0000, change_notify_ctrl_reg};
          gpio_cn_pkg::IDX_POS_EN:     rd_data <= {16'h0000, change_pos_enable_reg};
          gpio_cn_pkg::IDX_STATUS:     rd_data <= {16'h0000, change_status_reg};
          gpio_cn_pkg::IDX_NEG_EN:     rd_data <= {16'h0000, change_neg_enable_reg};
          gpio_cn_pkg::IDX_EDGE_FLAG:  rd_data <= {16'h0000, change_edge_flag_reg};
          default:                     rd_data <= '0;
        endcase
      end
    end
  end
endmodule // io_port_change_notify

// ---- design/pin_sync.sv ----
// three-stage pin synchroniser with agreement filter
`timescale 1ns/1ps
module pin_sync (
  input  wire logic                           clk,
  input  wire logic                           sys_rst,
  input  wire logic [gpio_cn_pkg::NPINS-1:0]  pin_raw,
  output logic      [gpio_cn_pkg::NPINS-1:0]  pin_level
);
  logic [gpio_cn_pkg::NPINS-1:0] stage1;
  logic [gpio_cn_pkg::NPINS-1:0] stage2;
  logic [gpio_cn_pkg::NPINS-1:0] stage3;

  genvar i;
  generate
    for (i = 0; i < gpio_cn_pkg::NPINS; i++) begin : g_pin
      always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
          stage1[i]    <= 1'b0;
          stage2[i]    <= 1'b0;
          stage3[i]    <= 1'b0;
          pin_level[i] <= 1'b0;
        end else begin
          stage1[i] <= pin_raw[i];
          stage2[i] <= stage1[i];
          stage3[i] <= stage2[i];
          if (stage2[i] == stage3[i]) begin
            pin_level[i] <= stage3[i];
          end
        end
      end
    end
  endgenerate
endmodule // pin_sync

// ---- testbench/io_port_props.sv ----
// concurrent checks on the i/o port bus and pad outputs
`timescale 1ns/1ps
module io_port_props (
  input wire logic        clk,
  input wire logic        sys_rst,
  input wire logic [7:0]  addr,
  input wire logic [31:0] wr_data,
  input wire logic        wr_en,
  input wire logic        rd_en,
  input wire logic [31:0] rd_data,
  input wire logic [15:0] pin_oe,
  input wire logic [15:0] pullup_en,
  input wire logic [15:0] pulldown_en,
  input wire logic [15:0] analog_en,
  input wire logic        cn_irq
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  rd_idle_zero_a: assert property (!$past(rd_en) |-> rd_data == 32'h0)
    else $error("read data not zero outside read cycle");
  rd_upper_a: assert property (rd_data[31:16] == 16'h0)
    else $error("upper read half not zero");
  unmapped_rd_a: assert property ($past(rd_en) && $past(addr[7:6]) == 2'h3 |-> rd_data == 32'h0)
    else $error("unmapped read not zero");
  reset_state_a: assert property ($past(sys_rst) |-> pin_oe == 16'h0 && analog_en == 16'hFFFF && !cn_irq)
    else $error("pads not in reset state");
  dir_input_a: assert property (wr_en && addr == 8'h10 ##1 !(wr_en && addr[7:4] == 4'h1)
    |=> (pin_oe & $past(wr_data[15:0], 2)) == 16'h0) else $error("input pin still driven");
  analog_copy_a: assert property (wr_en && addr == 8'h00 ##1 !(wr_en && addr[7:4] == 4'h0)
    |=> analog_en == $past(wr_data[15:0], 2)) else $error("analog select not applied");
  pullup_set_a: assert property (wr_en && addr == 8'h58 ##1 !(wr_en && addr[7:4] == 4'h5)
    |=> (pullup_en & $past(wr_data[15:0], 2)) == $past(wr_data[15:0], 2)) else $error("pull-up set failed");
  pulldown_clr_a: assert property (wr_en && addr == 8'h64 ##1 !(wr_en && addr[7:4] == 4'h6)
    |=> (pulldown_en & $past(wr_data[15:0], 2)) == 16'h0) else $error("pull-down clear failed");
  irq_off_a: assert property (wr_en && addr == 8'h74 && wr_data[15] ##1 !wr_en |=> !cn_irq)
    else $error("interrupt stays with notification off");
endmodule // io_port_props

bind io_port_change_notify io_port_props i_props (.clk(clk), .sys_rst(sys_rst), .addr(addr), .wr_data(wr_data),
  .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data), .pin_oe(pin_oe), .pullup_en(pullup_en),
  .pulldown_en(pulldown_en), .analog_en(analog_en), .cn_irq(cn_irq));

// ---- testbench/pad_model.sv ----
// pad and board model: drivers, weak pulls, external sources, floating lines
`timescale 1ns/1ps
module pad_model (
  input  wire logic        clk,
  input  wire logic [15:0] pin_out,
  input  wire logic [15:0] pin_oe,
  input  wire logic [15:0] pullup_en,
  input  wire logic [15:0] pulldown_en,
  input  wire logic [15:0] ext_val,
  input  wire logic [15:0] ext_en,
  output logic      [15:0] pin_in
);
  logic [15:0] float_q = 16'h0000;
  logic [15:0] driven;
  // a floating line keeps the inverse of the level it last had while driven or pulled
  assign driven = pin_oe | ext_en | pullup_en | pulldown_en;
  always @(posedge clk) float_q <= (driven & ~pin_in) | (~driven & float_q);
  always_comb begin
    for (int i = 0; i < 16; i++) begin
      if (pin_oe[i]) pin_in[i] = pin_out[i];
      else if (ext_en[i]) pin_in[i] = ext_val[i];
      else if (pullup_en[i]) pin_in[i] = 1'b1;
      else if (pulldown_en[i]) pin_in[i] = 1'b0;
      else pin_in[i] = float_q[i];
    end
  end
endmodule // pad_model

// ---- testbench/tb_top.sv ----
// self-checking bench for the i/o port with change notification
`timescale 1ns/1ps
module tb_top;
  logic        clk;
  logic        sys_rst;
  logic [7:0]  addr;
  logic [31:0] wr_data;
  logic        wr_en;
  logic        rd_en;
  logic [31:0] rd_data;
  logic [15:0] pin_in, pin_out, pin_oe, pullup_en, pulldown_en, analog_en;
  logic        cn_irq;
  logic [15:0] ext_val, ext_en;
  int          bad_count, num_checks;

  io_port_change_notify i_dut (.clk(clk), .sys_rst(sys_rst), .addr(addr), .wr_data(wr_data), .wr_en(wr_en),
    .rd_en(rd_en), .rd_data(rd_data), .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe),
    .pullup_en(pullup_en), .pulldown_en(pulldown_en), .analog_en(analog_en), .cn_irq(cn_irq));
  pad_model i_pad (.clk(clk), .pin_out(pin_out), .pin_oe(pin_oe), .pullup_en(pullup_en),
    .pulldown_en(pulldown_en), .ext_val(ext_val), .ext_en(ext_en), .pin_in(pin_in));

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic bus_wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk);
    addr    <= a;
    wr_data <= {16'h0000, d};
    wr_en   <= 1'b1;
    @(posedge clk);
    wr_en <= 1'b0;
  endtask
  task automatic bus_rd(input logic [7:0] a, input logic [15:0] exp, input logic [15:0] mask);
    @(posedge clk);
    addr  <= a;
    rd_en <= 1'b1;
    @(posedge clk);
    rd_en <= 1'b0;
    #1;
    check(rd_data & {16'hFFFF, mask}, {16'h0000, exp & mask});
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic drive_ext(input logic [15:0] v, input logic [15:0] en);
    @(posedge clk);
    ext_val <= v;
    ext_en  <= en;
  endtask
  task automatic complete_run;
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  task automatic t_reset;
    check({16'h0000, pin_oe}, 32'h0);
    bus_rd(8'h00, 16'hFFFF, 16'hFFFF);
    bus_rd(8'h10, 16'hFFFF, 16'hFFFF);
    bus_wr(8'hC0, 16'hFFFF);
    bus_rd(8'hC0, 16'h0000, 16'hFFFF);
    bus_rd(8'h70, 16'h0000, 16'hFFFF);
  endtask
  task automatic t_latch;
    bus_wr(8'h00, 16'h0000);
    bus_wr(8'h10, 16'h0000);
    bus_wr(8'h20, 16'hA5C3);
    bus_rd(8'h30, 16'hA5C3, 16'hFFFF);
    idle(6);
    bus_rd(8'h20, 16'hA5C3, 16'hFFFF);
    check({pin_oe, pin_out}, 32'hFFFFA5C3);
  endtask
  task automatic t_alias;
    logic [15:0] exp;
    exp = 16'hA5C3;
    for (int op = 1; op < 4; op++) begin
      bus_wr(8'h30 | 8'(op * 4), 16'h0FF0);
      exp = (op == 1) ? exp & ~16'h0FF0 : (op == 2) ? exp | 16'h0FF0 : exp ^ 16'h0FF0;
      bus_rd(8'h30, exp, 16'hFFFF);
    end
  endtask
  task automatic t_odc;
    bus_wr(8'h40, 16'hFFFF);
    idle(2);
    check({pin_oe, pin_out}, {~16'hA003, 16'h0000});
    bus_wr(8'h40, 16'h0000);
  endtask
  task automatic t_pulls;
    bus_wr(8'h10, 16'hFFFF);
    bus_wr(8'h58, 16'h00F0);
    bus_wr(8'h68, 16'h0F00);
    idle(6);
    check({pullup_en, pulldown_en}, 32'h00F00F00);
    bus_rd(8'h20, 16'h00F0, 16'h0FF0);
    bus_wr(8'h54, 16'h00F0);
    bus_wr(8'h64, 16'h0F00);
  endtask
  task automatic t_analog;
    drive_ext(16'hFFFF, 16'hFFFF);
    bus_wr(8'h00, 16'h00FF);
    idle(6);
    bus_rd(8'h20, 16'hFF00, 16'hFFFF);
    bus_wr(8'h00, 16'hFFFF);
    bus_wr(8'h10, 16'h0000);
    idle(2);
    check({pin_oe, analog_en}, 32'hFFFFFFFF);
    bus_wr(8'h10, 16'hFFFF);
    bus_wr(8'h00, 16'h0000);
  endtask
  task automatic t_mismatch;
    drive_ext(16'h0000, 16'hFFFF);
    bus_wr(8'h70, 16'h8000);
    bus_wr(8'h80, 16'h0001);
    idle(6);
    bus_rd(8'h20, 16'h0000, 16'hFFFF);
    drive_ext(16'h0003, 16'hFFFF);
    idle(8);
    check({31'h0, cn_irq}, 32'h1);
    bus_rd(8'h90, 16'h0001, 16'hFFFF);
    bus_rd(8'h20, 16'h0003, 16'hFFFF);
    idle(3);
    check({31'h0, cn_irq}, 32'h0);
  endtask
  task automatic t_edge;
    bus_wr(8'h70, 16'h8800);
    bus_wr(8'hA0, 16'h0002);
    bus_wr(8'hB0, 16'h0000);
    drive_ext(16'h0000, 16'hFFFF);
    idle(8);
    drive_ext(16'h0001, 16'hFFFF);
    idle(8);
    bus_rd(8'hB0, 16'h0003, 16'hFFFF);
    check({31'h0, cn_irq}, 32'h1);
    bus_wr(8'h74, 16'h8000);
    idle(2);
    check({31'h0, cn_irq}, 32'h0);
  endtask

  initial begin
    sys_rst    = 1'b1;
    addr       = 8'h00;
    wr_data    = 32'h0;
    wr_en      = 1'b0;
    rd_en      = 1'b0;
    ext_val    = 16'h0000;
    ext_en     = 16'h0000;
    bad_count  = 0;
    num_checks = 0;
    repeat (3) @(posedge clk);
    sys_rst <= 1'b0;
    idle(1);
    t_reset();
    t_latch();
    t_alias();
    t_odc();
    t_pulls();
    t_analog();
    t_mismatch();
    t_edge();
    complete_run();
  end

  initial begin
    #40000;
    bad_count++;
    complete_run();
  end
endmodule // tb_top
